// ### hdl/usbtc_top.sv
`timescale 1ns/10ps
// What this block does
// R1 - pull-up enables connect 1.5k resistors
// R2 - pull-down enables connect 15k resistors
// R3 - high-speed termination on both lines together
// R4 - enables decoded from function and OTG fields
// R5 - synchronous mode: resistors follow mode only
// R6 - operating_mode 01b turns all enables off
// R7 - power-up or low VBUS: pull-downs only
// R8 - host: pull-downs, HS term only HS
// R9 - peripheral HS/test: only HS termination
// R10 - peripheral FS/LS: single matching pull-up
// R11 - OTG peripheral FS: DP up, DM down
// R12 - OTG peripheral HS: HS term, DM down
// R13 - connect detect: only DM pull-down
// R14 - undefined combination falls back to pull-downs
// R15 - link programs only defined combinations
// R16 - reset pin low tri-states drivers
// R17 - receiver chosen by mode feeds receive logic
// R18 - HS squelch keeps noise out of data
// R19 - single-ended receivers give line state
// R20 - transmit data encoded, stuffed, serialised
// R21 - amplitude boost scales HS transmit level
// R22 - squelch sensitivity lowers HS threshold
// R23 - enables change cycle after the write
module usbtc_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // vbus comparator
    input  wire logic        vbus_below_session_end,
    // line receivers
    input  wire logic        hs_rx_bit,
    input  wire logic        hs_squelch,
    input  wire logic        fs_rx_bit,
    input  wire logic        dp_se_rx,
    input  wire logic        dm_se_rx,
    // receive logic side
    output logic             rx_bit,
    output logic             rx_bit_valid,
    output logic [1:0]       line_state,
    // transmitters and squelch trim
    output logic             hs_tx_en,
    output logic             fs_tx_en,
    output logic             tx_line,
    output logic [2:0]       hs_amplitude_trim,
    output logic [1:0]       squelch_trim,
    // termination resistors
    output logic             dplus_pullup_enable,
    output logic             dminus_pullup_enable,
    output logic             dplus_pulldown_on,
    output logic             dminus_pulldown_on,
    output logic             highspeed_termination_on
);
    usbtc_pkg::usbtc_func_s   func_ff, nxt_func;
    usbtc_pkg::usbtc_otg_s    otg_ff, nxt_otg;
    usbtc_pkg::usbtc_hscomp_s hscomp_ff;
    usbtc_pkg::usbtc_term_s   term_ff, nxt_term;
    usbtc_pkg::usbtc_tx_e     tx_state_ff;

    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic        rx_bit_ff;
    logic        rx_valid_ff;
    logic [1:0]  line_ff;
    logic [7:0]  rx_shift_ff;
    logic [7:0]  tx_shift_ff;
    logic [3:0]  tx_cnt_ff;
    logic [2:0]  ones_ff;
    logic [3:0]  div_ff;
    logic        tx_line_ff;
    logic        hs_tx_ff;
    logic        fs_tx_ff;
    logic        hs_sel;
    logic        bit_en;
    logic        acc;
    logic        wr_go;
    logic        tx_blocked;
    logic [31:0] rd_mux;

    assign hs_sel = func_ff.transceiver_select == usbtc_pkg::XCVR_HS;

    // bus handshake
    // a transmit write is held off while a byte is on the wire
    assign tx_blocked = avs_write && tx_state_ff != usbtc_pkg::TX_IDLE
                        && avs_address == usbtc_pkg::OFS_TXDATA;
    assign acc   = (avs_read || avs_write) && wait_ff && !tx_blocked;
    assign wr_go = avs_write && !wait_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !acc;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            usbtc_pkg::OFS_FUNC:   rd_mux[4:0] = func_ff;
            usbtc_pkg::OFS_OTG:
                rd_mux[usbtc_pkg::OTG_PD_LSB +: 2] = otg_ff;
            usbtc_pkg::OFS_HSCOMP: rd_mux[4:0] = hscomp_ff;
            usbtc_pkg::OFS_STATUS: begin
                rd_mux[usbtc_pkg::ST_LINE_LSB +: 2] = line_ff;
                rd_mux[usbtc_pkg::ST_SQUELCH] = hs_squelch;
                rd_mux[usbtc_pkg::ST_TX_BUSY] =
                    tx_state_ff != usbtc_pkg::TX_IDLE;
            end
            usbtc_pkg::OFS_TXDATA: rd_mux[7:0] = tx_shift_ff;
            usbtc_pkg::OFS_RXDATA: rd_mux[7:0] = rx_shift_ff;
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (acc && avs_read) begin
            rdata_ff <= rd_mux;
        end
    end

    // control fields; low VBUS forces the power-up set
    always_comb begin
        nxt_func = func_ff;
        nxt_otg  = otg_ff;
        if (wr_go && avs_byteenable[0]) begin // R4
            if (avs_address == usbtc_pkg::OFS_FUNC) begin
                nxt_func = avs_writedata[4:0];
            end
            if (avs_address == usbtc_pkg::OFS_OTG) begin
                nxt_otg = avs_writedata[usbtc_pkg::OTG_PD_LSB +: 2];
            end
        end
        if (vbus_below_session_end) begin
            nxt_func = usbtc_pkg::FUNC_RST; // R7
            nxt_otg  = usbtc_pkg::OTG_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            func_ff <= usbtc_pkg::FUNC_RST; // R7
            otg_ff  <= usbtc_pkg::OTG_RST;
        end else begin
            func_ff <= nxt_func;
            otg_ff  <= nxt_otg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            hscomp_ff <= usbtc_pkg::HSCOMP_RST;
        end else if (wr_go && avs_byteenable[0] &&
                     avs_address == usbtc_pkg::OFS_HSCOMP) begin
            hscomp_ff <= avs_writedata[4:0];
        end
    end

    // decoding the next fields lets the enables move with the write
    usbtc_term_decode u_decode (
        .func (nxt_func),
        .otg  (nxt_otg),
        .term (nxt_term)
    );

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            term_ff <= usbtc_pkg::TERM_OFF; // R16
        end else begin
            term_ff <= nxt_term; // R5 R23
        end
    end

    // receive path
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_bit_ff   <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_shift_ff <= 8'h00;
        end else if (hs_sel) begin
            rx_bit_ff   <= hs_rx_bit; // R17
            rx_valid_ff <= !hs_squelch; // R18
            if (!hs_squelch) begin
                rx_shift_ff <= {hs_rx_bit, rx_shift_ff[7:1]};
            end
        end else begin
            rx_bit_ff   <= fs_rx_bit; // R17
            rx_valid_ff <= 1'b1;
            rx_shift_ff <= {fs_rx_bit, rx_shift_ff[7:1]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            line_ff <= 2'h0;
        end else begin
            line_ff <= {dm_se_rx, dp_se_rx}; // R19
        end
    end

    // transmit bit-rate divider
    always_ff @(posedge core_clk) begin
        if (!rstn || tx_state_ff == usbtc_pkg::TX_IDLE) begin
            div_ff <= 4'h0;
        end else if (div_ff == usbtc_pkg::TX_DIV_LAST) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign bit_en = tx_state_ff == usbtc_pkg::TX_SHIFT &&
                    div_ff == usbtc_pkg::TX_DIV_LAST;

    // nrzi encoder with bit stuffing, lsb first
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_state_ff <= usbtc_pkg::TX_IDLE;
            tx_shift_ff <= 8'h00;
            tx_cnt_ff   <= 4'h0;
            ones_ff     <= 3'h0;
            tx_line_ff  <= 1'b1;
            hs_tx_ff    <= 1'b0;
            fs_tx_ff    <= 1'b0;
        end else begin
            case (tx_state_ff)
                usbtc_pkg::TX_IDLE: begin
                    if (wr_go && avs_byteenable[0] &&
                        avs_address == usbtc_pkg::OFS_TXDATA) begin
                        tx_shift_ff <= avs_writedata[7:0]; // R20
                        tx_cnt_ff   <= 4'h0;
                        tx_state_ff <= usbtc_pkg::TX_SHIFT;
                        hs_tx_ff    <= hs_sel;
                        fs_tx_ff    <= !hs_sel;
                    end
                end
                usbtc_pkg::TX_SHIFT: begin
                    if (bit_en) begin
                        if (ones_ff == usbtc_pkg::STUFF_LIMIT) begin
                            tx_line_ff <= !tx_line_ff; // R20
                            ones_ff    <= 3'h0;
                        end else if (tx_cnt_ff == usbtc_pkg::TX_BITS) begin
                            tx_state_ff <= usbtc_pkg::TX_IDLE;
                            hs_tx_ff    <= 1'b0;
                            fs_tx_ff    <= 1'b0;
                        end else begin
                            if (tx_shift_ff[0]) begin
                                ones_ff <= ones_ff + 3'h1;
                            end else begin
                                tx_line_ff <= !tx_line_ff;
                                ones_ff    <= 3'h0;
                            end
                            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
                            tx_cnt_ff   <= tx_cnt_ff + 4'h1;
                        end
                    end
                end
                default: begin
                    tx_state_ff <= usbtc_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // outputs
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign rx_bit          = rx_bit_ff;
    assign rx_bit_valid    = rx_valid_ff;
    assign line_state      = line_ff;
    assign hs_tx_en        = hs_tx_ff;
    assign fs_tx_en        = fs_tx_ff;
    assign tx_line         = tx_line_ff;
    assign hs_amplitude_trim = hscomp_ff.tx_amplitude_boost; // R21
    assign squelch_trim      = hscomp_ff.squelch_sensitivity; // R22
    assign dplus_pullup_enable      = term_ff.dplus_pullup_enable;
    assign dminus_pullup_enable     = term_ff.dminus_pullup_enable;
    assign dplus_pulldown_on        = term_ff.dplus_pulldown_on;
    assign dminus_pulldown_on       = term_ff.dminus_pulldown_on;
    assign highspeed_termination_on = term_ff.highspeed_termination_on;

    // checks
    AST_RESET_TRISTATE: // R16
    assert property (@(posedge core_clk) !rstn |=> term_ff == '0)
    else $error("enables not off after reset");

    AST_NONDRIVE_OFF: // R6
    assert property (@(posedge core_clk) disable iff (!rstn)
        func_ff.operating_mode == usbtc_pkg::OPM_NONDRIVE
        |-> term_ff == '0)
    else $error("non-driving mode left an enable on");

    AST_LOW_VBUS_PULLDOWNS: // R7
    assert property (@(posedge core_clk) disable iff (!rstn)
        vbus_below_session_end |=> term_ff == usbtc_pkg::TERM_PD)
    else $error("low vbus did not select pull-downs only");

    AST_HS_TERM_CAUSE: // R3
    assert property (@(posedge core_clk) disable iff (!rstn)
        term_ff.highspeed_termination_on |->
        hs_sel && !func_ff.termination_select &&
        !term_ff.dplus_pullup_enable && !term_ff.dminus_pullup_enable)
    else $error("hs termination in wrong state");

    AST_PULLUP_EXCLUSIVE: // R1
    assert property (@(posedge core_clk) disable iff (!rstn)
        !(term_ff.dplus_pullup_enable && term_ff.dminus_pullup_enable))
    else $error("both pull-ups on");

    AST_WRITE_TO_ENABLE: // R23
    assert property (@(posedge core_clk) disable iff (!rstn)
        wr_go && avs_address == usbtc_pkg::OFS_FUNC &&
        avs_byteenable[0] && !vbus_below_session_end &&
        avs_writedata[4:3] == usbtc_pkg::OPM_NONDRIVE
        |=> term_ff == '0)
    else $error("enables did not follow the write");

    AST_SQUELCH_BLOCKS: // R18
    assert property (@(posedge core_clk) disable iff (!rstn)
        hs_sel && hs_squelch |=> !rx_valid_ff)
    else $error("squelched line accepted as data");

    AST_LINE_STATE: // R19
    assert property (@(posedge core_clk) disable iff (!rstn)
        1'b1 |=> line_ff == {$past(dm_se_rx), $past(dp_se_rx)})
    else $error("line state not from single-ended receivers");

    AST_STUFF_LIMIT: // R20
    assert property (@(posedge core_clk) disable iff (!rstn)
        ones_ff <= usbtc_pkg::STUFF_LIMIT)
    else $error("run of ones beyond stuffing limit");

    AST_WAIT_PULSE:
    assert property (@(posedge core_clk) disable iff (!rstn)
        !wait_ff |=> wait_ff)
    else $error("waitrequest low for more than one cycle");
endmodule

// ### hdl/usbtc_pkg.sv
package usbtc_pkg;
    // clock and transmit bit timing
    localparam int CLK_MHZ    = 100;
    localparam int TX_BIT_NS  = 20;
    localparam int TX_BIT_CYC = (TX_BIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] TX_DIV_LAST = 4'(TX_BIT_CYC - 1);

    // register byte addresses
    localparam logic [4:0] OFS_FUNC   = 5'h00;
    localparam logic [4:0] OFS_OTG    = 5'h04;
    localparam logic [4:0] OFS_HSCOMP = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_TXDATA = 5'h10;
    localparam logic [4:0] OFS_RXDATA = 5'h14;

    // transceiver_select codes
    localparam logic [1:0] XCVR_HS    = 2'h0;
    localparam logic [1:0] XCVR_FS    = 2'h1;
    localparam logic [1:0] XCVR_LS    = 2'h2;
    localparam logic [1:0] XCVR_FS4LS = 2'h3;

    // operating_mode codes
    localparam logic [1:0] OPM_NORMAL   = 2'h0;
    localparam logic [1:0] OPM_NONDRIVE = 2'h1;
    localparam logic [1:0] OPM_NOSTUFF  = 2'h2;

    // field layouts
    localparam int OTG_PD_LSB   = 1;
    localparam int ST_LINE_LSB  = 0;
    localparam int ST_SQUELCH   = 2;
    localparam int ST_TX_BUSY   = 3;

    // transmit framing
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    localparam logic [3:0] TX_BITS     = 4'h8;

    typedef struct packed {
        logic [1:0] operating_mode;
        logic       termination_select;
        logic [1:0] transceiver_select;
    } usbtc_func_s;

    typedef struct packed {
        logic dminus_pulldown_request;
        logic dplus_pulldown_request;
    } usbtc_otg_s;

    typedef struct packed {
        logic [1:0] squelch_sensitivity;
        logic [2:0] tx_amplitude_boost;
    } usbtc_hscomp_s;

    typedef struct packed {
        logic dplus_pullup_enable;
        logic dminus_pullup_enable;
        logic dplus_pulldown_on;
        logic dminus_pulldown_on;
        logic highspeed_termination_on;
    } usbtc_term_s;

    localparam usbtc_func_s FUNC_RST = '{OPM_NORMAL, 1'b0, XCVR_FS};
    localparam usbtc_otg_s  OTG_RST  = '{1'b1, 1'b1};
    localparam usbtc_hscomp_s HSCOMP_RST = '{2'h0, 3'h0};
    localparam usbtc_term_s TERM_OFF = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    localparam usbtc_term_s TERM_PD  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    typedef enum logic {TX_IDLE, TX_SHIFT} usbtc_tx_e;
endpackage

// ### hdl/usbtc_term_decode.sv
`timescale 1ns/10ps
module usbtc_term_decode (
    // control fields
    input  wire usbtc_pkg::usbtc_func_s func,
    input  wire usbtc_pkg::usbtc_otg_s  otg,
    // resistor enables
    output usbtc_pkg::usbtc_term_s      term
);
    logic [1:0] xs;
    logic [1:0] om;
    logic       ts;
    logic       run;
    logic       fsr;
    logic       lsr;

    assign xs  = func.transceiver_select;
    assign om  = func.operating_mode;
    assign ts  = func.termination_select;
    // normal or chirp/resume signalling
    assign run = (om == usbtc_pkg::OPM_NORMAL) ||
                 (om == usbtc_pkg::OPM_NOSTUFF);
    assign fsr = (xs == usbtc_pkg::XCVR_FS) && run;
    assign lsr = (xs == usbtc_pkg::XCVR_LS) && run;

    always_comb begin
        term = usbtc_pkg::TERM_PD; // R14
        if (om == usbtc_pkg::OPM_NONDRIVE) begin
            term = usbtc_pkg::TERM_OFF; // R6
        end else begin
            case ({otg.dplus_pulldown_request,
                   otg.dminus_pulldown_request})
                2'h3: begin // R8
                    if (xs == usbtc_pkg::XCVR_HS && !ts && run) begin
                        term.highspeed_termination_on = 1'b1; // R3
                    end
                end
                2'h0: begin
                    if (xs == usbtc_pkg::XCVR_HS && !ts && run) begin
                        term = usbtc_pkg::TERM_OFF; // R9
                        term.highspeed_termination_on = 1'b1;
                    end else if (ts && (fsr || (xs ==
                            usbtc_pkg::XCVR_HS &&
                            om == usbtc_pkg::OPM_NOSTUFF))) begin
                        term = usbtc_pkg::TERM_OFF; // R10
                        term.dplus_pullup_enable = 1'b1; // R1
                    end else if (ts && lsr) begin
                        term = usbtc_pkg::TERM_OFF; // R10
                        term.dminus_pullup_enable = 1'b1; // R1
                    end
                end
                2'h1: begin
                    if (xs == usbtc_pkg::XCVR_HS && !ts && run) begin
                        term = usbtc_pkg::TERM_OFF; // R12
                        term.highspeed_termination_on = 1'b1;
                        term.dminus_pulldown_on = 1'b1; // R2
                    end else if (ts && (fsr || (xs ==
                            usbtc_pkg::XCVR_HS &&
                            om == usbtc_pkg::OPM_NOSTUFF))) begin
                        term = usbtc_pkg::TERM_OFF; // R11
                        term.dplus_pullup_enable = 1'b1;
                        term.dminus_pulldown_on = 1'b1;
                    end else if (!ts && xs == usbtc_pkg::XCVR_FS &&
                            om == usbtc_pkg::OPM_NORMAL) begin
                        term = usbtc_pkg::TERM_OFF; // R13
                        term.dminus_pulldown_on = 1'b1;
                    end
                end
                default: begin
                    term = usbtc_pkg::TERM_PD;
                end
            endcase
        end
    end
endmodule

// ### testbench/usbtc_line_model.sv
`timescale 1ns/10ps
module usbtc_line_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // from bench and transmitter
    input  wire logic       squelch_req,
    input  wire logic       tx_line,
    input  wire logic       tx_en,
    // line receivers and transmit toggle count
    output logic            hs_rx_bit,
    output logic            hs_squelch,
    output logic            fs_rx_bit,
    output logic            dp_se_rx,
    output logic            dm_se_rx,
    output logic [7:0]      toggle_cnt
);
    logic [2:0] pat_ff;
    logic       last_ff;

    // each receiver gets a different pattern so a swapped mux shows up
    always @(posedge core_clk) begin
        pat_ff     <= rstn ? pat_ff + 3'h1 : 3'h0;
        hs_rx_bit  <= pat_ff[0];
        fs_rx_bit  <= ~pat_ff[1];
        dp_se_rx   <= pat_ff[1] ^ pat_ff[0];
        dm_se_rx   <= pat_ff[2];
        hs_squelch <= squelch_req;
    end

    always @(posedge core_clk) begin
        last_ff <= tx_line;
        if (!rstn) begin
            toggle_cnt <= 8'h00;
        end else if (tx_en && tx_line != last_ff) begin
            toggle_cnt <= toggle_cnt + 8'h01;
        end
    end
endmodule

// ### testbench/usb_termination_control_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end

module usb_termination_control_tb;
    logic        core_clk;
    logic        rstn;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        vbus_below_session_end;
    logic        hs_rx_bit;
    logic        hs_squelch;
    logic        fs_rx_bit;
    logic        dp_se_rx;
    logic        dm_se_rx;
    logic        rx_bit;
    logic        rx_bit_valid;
    logic [1:0]  line_state;
    logic        hs_tx_en;
    logic        fs_tx_en;
    logic        tx_line;
    logic [2:0]  hs_amplitude_trim;
    logic [1:0]  squelch_trim;
    logic        squelch_req;
    logic [7:0]  toggle_cnt;
    logic [31:0] rd;
    int          n_errors;
    int          checks;

    usbtc_pkg::usbtc_term_s term;

    usbtc_top dut (
        .core_clk                 (core_clk),
        .rstn                     (rstn),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_byteenable           (avs_byteenable),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .vbus_below_session_end   (vbus_below_session_end),
        .hs_rx_bit                (hs_rx_bit),
        .hs_squelch               (hs_squelch),
        .fs_rx_bit                (fs_rx_bit),
        .dp_se_rx                 (dp_se_rx),
        .dm_se_rx                 (dm_se_rx),
        .rx_bit                   (rx_bit),
        .rx_bit_valid             (rx_bit_valid),
        .line_state               (line_state),
        .hs_tx_en                 (hs_tx_en),
        .fs_tx_en                 (fs_tx_en),
        .tx_line                  (tx_line),
        .hs_amplitude_trim        (hs_amplitude_trim),
        .squelch_trim             (squelch_trim),
        .dplus_pullup_enable      (term.dplus_pullup_enable),
        .dminus_pullup_enable     (term.dminus_pullup_enable),
        .dplus_pulldown_on        (term.dplus_pulldown_on),
        .dminus_pulldown_on       (term.dminus_pulldown_on),
        .highspeed_termination_on (term.highspeed_termination_on)
    );

    usbtc_line_model line (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .squelch_req (squelch_req),
        .tx_line     (tx_line),
        .tx_en       (hs_tx_en | fs_tx_en),
        .hs_rx_bit   (hs_rx_bit),
        .hs_squelch  (hs_squelch),
        .fs_rx_bit   (fs_rx_bit),
        .dp_se_rx    (dp_se_rx),
        .dm_se_rx    (dm_se_rx),
        .toggle_cnt  (toggle_cnt)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic stop_if(input logic hit);
        if (hit) begin
            n_errors++;
            tally_and_finish();
        end
    endtask

    // held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge core_clk);
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        for (k = 0; k < 50; k++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        #1;
        stop_if(k == 50);
    endtask

    task automatic row(input logic [4:0] f, input logic [7:0] o,
                       input logic [4:0] e);
        bus(1'b1, usbtc_pkg::OFS_OTG, {24'h0, o}, 4'hF);
        bus(1'b1, usbtc_pkg::OFS_FUNC, {27'h0, f}, 4'hF);
        `CHK("enables", e, term);
    endtask

    task automatic rx_chk(input logic hs);
        logic       eb;
        logic       ev;
        logic [1:0] el;
        repeat (6) begin
            eb = hs ? hs_rx_bit : fs_rx_bit;
            ev = hs ? !hs_squelch : 1'b1;
            el = {dm_se_rx, dp_se_rx};
            @(posedge core_clk);
            squelch_req <= ~squelch_req;
            #1;
            `CHK("rx_bit", eb, rx_bit);
            `CHK("rx_bit_valid", ev, rx_bit_valid);
            `CHK("line_state", el, line_state);
        end
    endtask

    task automatic tx_chk(input logic [7:0] d, input logic [4:0] f,
                          input logic hs, input logic [7:0] n);
        logic [7:0] c0;
        int         k;
        bus(1'b1, usbtc_pkg::OFS_FUNC, {27'h0, f}, 4'hF);
        c0 = toggle_cnt;
        bus(1'b1, usbtc_pkg::OFS_TXDATA, {24'h0, d}, 4'hF);
        `CHK("tx enable", hs, hs_tx_en);
        `CHK("other tx enable", !hs, fs_tx_en);
        for (k = 0; k < 100 && (hs_tx_en | fs_tx_en) !== 1'b0; k++)
            @(negedge core_clk);
        stop_if(k == 100);
        `CHK("tx toggles", n, 8'(toggle_cnt - c0));
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        stop_if(1'b1);
    end

    initial begin
        rstn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        vbus_below_session_end = 1'b0;
        squelch_req = 1'b0;
        n_errors = 0;
        checks = 0;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("enables in reset", 5'h00, term);
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("enables after reset", 5'h06, term);
        $display("test reset done");

        bus(1'b0, usbtc_pkg::OFS_FUNC, 32'h0, 4'hF);
        `CHK("func reset", 32'h01, rd);
        bus(1'b0, usbtc_pkg::OFS_OTG, 32'h0, 4'hF);
        `CHK("otg reset", 32'h06, rd);
        bus(1'b1, 5'h18, 32'hFF, 4'hF);
        bus(1'b0, 5'h18, 32'h0, 4'hF);
        `CHK("unmapped", 32'h0, rd);
        bus(1'b1, usbtc_pkg::OFS_HSCOMP, 32'h1D, 4'hF);
        bus(1'b0, usbtc_pkg::OFS_HSCOMP, 32'h0, 4'hF);
        `CHK("hscomp", 32'h1D, rd);
        `CHK("amplitude", 3'h5, hs_amplitude_trim);
        `CHK("squelch", 2'h3, squelch_trim);
        bus(1'b1, usbtc_pkg::OFS_FUNC, 32'hE5, 4'h0);
        bus(1'b0, usbtc_pkg::OFS_FUNC, 32'h0, 4'hF);
        `CHK("func lane off", 32'h01, rd);
        bus(1'b1, usbtc_pkg::OFS_FUNC, 32'hE5, 4'hF);
        bus(1'b0, usbtc_pkg::OFS_FUNC, 32'h0, 4'hF);
        `CHK("func width", 32'h05, rd);
        $display("test registers done");

        row(5'h10, 8'h06, 5'h07);
        row(5'h00, 8'h06, 5'h07);
        row(5'h05, 8'h06, 5'h06);
        row(5'h07, 8'h06, 5'h06);
        row(5'h15, 8'h06, 5'h06);
        row(5'h06, 8'h06, 5'h06);
        row(5'h16, 8'h06, 5'h06);
        row(5'h00, 8'h00, 5'h01);
        row(5'h10, 8'h00, 5'h01);
        row(5'h14, 8'h00, 5'h10);
        row(5'h05, 8'h00, 5'h10);
        row(5'h15, 8'h00, 5'h10);
        row(5'h06, 8'h00, 5'h08);
        row(5'h16, 8'h00, 5'h08);
        row(5'h14, 8'h04, 5'h12);
        row(5'h05, 8'h04, 5'h12);
        row(5'h15, 8'h04, 5'h12);
        row(5'h00, 8'h04, 5'h03);
        row(5'h10, 8'h04, 5'h03);
        row(5'h01, 8'h04, 5'h02);
        row(5'h01, 8'h06, 5'h06);
        row(5'h0D, 8'h06, 5'h00);
        row(5'h08, 8'h00, 5'h00);
        row(5'h03, 8'h00, 5'h06);
        row(5'h1D, 8'h00, 5'h06);
        row(5'h05, 8'h02, 5'h06);
        row(5'h07, 8'h00, 5'h06);
        $display("test decode table done");

        row(5'h05, 8'h00, 5'h10);
        @(posedge core_clk);
        vbus_below_session_end <= 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("enables low vbus", 5'h06, term);
        bus(1'b0, usbtc_pkg::OFS_FUNC, 32'h0, 4'hF);
        `CHK("func low vbus", 32'h01, rd);
        @(posedge core_clk);
        vbus_below_session_end <= 1'b0;
        $display("test vbus done");

        bus(1'b1, usbtc_pkg::OFS_FUNC, 32'h00, 4'hF);
        rx_chk(1'b1);
        bus(1'b1, usbtc_pkg::OFS_FUNC, 32'h05, 4'hF);
        rx_chk(1'b0);
        $display("test receive done");

        tx_chk(8'h00, 5'h00, 1'b1, 8'h08);
        tx_chk(8'h7E, 5'h05, 1'b0, 8'h03);
        tx_chk(8'hFF, 5'h05, 1'b0, 8'h01);
        $display("test transmit done");

        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("enables mid reset", 5'h00, term);
        @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("enables re-release", 5'h06, term);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
